/* File: sac_pkg.sv */
package sac_pkg;
   localparam int CH_W = 5;
   localparam int RES_W = 10;
   localparam logic [4:0] CH_EXT_LAST = 5'h0F;
   localparam logic [4:0] CH_GND_FIRST = 5'h10;
   localparam logic [4:0] CH_GND_LAST = 5'h15;
   localparam logic [4:0] CH_TEMP = 5'h1A;
   localparam logic [4:0] CH_BANDGAP = 5'h1B;
   localparam logic [4:0] CH_VREFH = 5'h1D;
   localparam logic [4:0] CH_VREFL = 5'h1E;
   localparam logic [4:0] CH_OFF = 5'h1F;
   localparam logic [1:0] CLK_BUS = 2'h0;
   localparam logic [1:0] CLK_BUS_HALF = 2'h1;
   localparam logic [1:0] CLK_ALT = 2'h2;
   localparam logic [1:0] CLK_ASYNC = 2'h3;
   localparam int DIV_W = 2;
   localparam int SAMPLE_SHORT = 4;
   localparam int SAMPLE_LONG = 24;
   localparam int CNT_W = 5;
   // Cycles for a new trial to come back through the comparator sync
   localparam int SETTLE = 3;
   localparam logic [1:0] PWR_RUN = 2'h0;
   localparam logic [1:0] PWR_WAIT = 2'h1;
   localparam logic [1:0] PWR_STOP3 = 2'h2;
   localparam logic [1:0] PWR_STOP2 = 2'h3;
   localparam logic [1:0] SRC_EXT = 2'h0;
   localparam logic [1:0] SRC_GND = 2'h1;
   localparam logic [1:0] SRC_INT = 2'h2;
   localparam logic [1:0] SRC_NONE = 2'h3;
   localparam logic [1:0] INT_TEMP = 2'h0;
   localparam logic [1:0] INT_BG = 2'h1;
   localparam logic [1:0] INT_VREFH = 2'h2;
   localparam logic [1:0] INT_VREFL = 2'h3;
endpackage

/* File: sac_tick_if.sv */
interface sac_tick_if;
   logic tick;
   logic [1:0] src;
   logic [1:0] div;
   logic [1:0] pwr;
   modport gen (output tick, input src, input div, input pwr);
   modport use_ (input tick, output src, output div, output pwr);
endinterface

/* File: sac_clkdiv.sv */
module sac_clkdiv (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic alt_tick,
   input wire logic async_tick,
   sac_tick_if.gen t
);
   logic half_q, half_d;
   logic [7:0] cnt_q, cnt_d;
   logic tick_q, tick_d;
   logic src_tick;
   logic [7:0] lim;

   // Source pick, then power-of-two divide
   always_comb begin
      half_d = ~half_q;
      lim = 8'h01 << t.div;
      case (t.src)
         sac_pkg::CLK_BUS: src_tick = 1'b1;
         sac_pkg::CLK_BUS_HALF: src_tick = half_q;
         // Alternate clock dead in both stop modes, shallow and deep
         sac_pkg::CLK_ALT: src_tick = alt_tick && (t.pwr != sac_pkg::PWR_STOP2)
            && (t.pwr != sac_pkg::PWR_STOP3);
         default: src_tick = async_tick;
      endcase
      cnt_d = cnt_q;
      tick_d = 1'b0;
      if (src_tick) begin
         if (cnt_q + 8'h01 >= lim) begin
            cnt_d = 8'h00;
            tick_d = 1'b1;
         end else begin
            cnt_d = cnt_q + 8'h01;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         half_q <= 1'b0;
         cnt_q <= 8'h00;
         tick_q <= 1'b0;
      end else begin
         half_q <= half_d;
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end
   assign t.tick = tick_q;
endmodule

/* File: sac_sar.sv */
module sac_sar #(
   parameter int RES_W = 10
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic start,
   input wire logic abort,
   input wire logic cmp_in,
   output logic [RES_W-1:0] trial,
   output logic busy,
   output logic done
);
   logic [RES_W-1:0] res_q, res_d;
   logic [RES_W-1:0] bit_q, bit_d;
   logic busy_q, busy_d;
   logic done_q, done_d;
   logic pend_q, pend_d;
   logic [1:0] wait_q, wait_d;
   logic step;

   // One bit per conversion clock, top bit first; a bit is decided only once
   // the trial has come back through the comparator sync, so a fast clock
   // is stretched rather than deciding on a stale answer
   always_comb begin
      res_d = res_q;
      bit_d = bit_q;
      busy_d = busy_q;
      done_d = 1'b0;
      pend_d = pend_q | tick;
      wait_d = (wait_q == 2'h0) ? 2'h0 : wait_q - 2'h1;
      step = busy_q && pend_q && (wait_q == 2'h0);
      if (abort || start) begin
         busy_d = start;
         pend_d = 1'b0;
         wait_d = 2'(sac_pkg::SETTLE);
         bit_d = {1'b1, {(RES_W-1){1'b0}}};
         res_d = {1'b1, {(RES_W-1){1'b0}}};
      end else if (step) begin
         pend_d = tick;
         wait_d = 2'(sac_pkg::SETTLE);
         if (!cmp_in)
            res_d = res_q & ~bit_q;
         bit_d = bit_q >> 1;
         res_d = res_d | (bit_q >> 1);
         if (bit_q[0]) begin
            busy_d = 1'b0;
            done_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         res_q <= '0;
         bit_q <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         pend_q <= 1'b0;
         wait_q <= 2'h0;
      end else begin
         res_q <= res_d;
         bit_q <= bit_d;
         busy_q <= busy_d;
         done_q <= done_d;
         pend_q <= pend_d;
         wait_q <= wait_d;
      end
   end
   assign trial = res_q;
   assign busy = busy_q;
   assign done = done_q;
endmodule

/* File: sac_ctrl.sv */
// Functional notes
// - Codes 0-15 pick external inputs, 16-21 pick ground.
// - Reserved channel codes give an undefined result, no error.
// - Channel codes 22-25 and 28 are reserved.
// - Code 26 routes temperature sensor, code 27 the bandgap.
// - Input clock is bus, bus halved, async or alternate clock.
// - Selected clock is divided by a programmable field.
// - Alternate clock keeps running in wait mode.
// - Alternate clock is unusable in either stop mode, shallow or deep.
// - With hardware trigger on, each counter overflow starts conversion (overflows while sampling or converting are ignored).
// - Counter interrupt enable does not gate the trigger.
// - Hardware trigger works in run, wait and shallow stop.
// - Successive approximation search yields a ten bit result.
// - Result right-justified unsigned, ten or eight bit.
// - Single and continuous modes; single returns to idle (to armed when hardware trigger is on).
// - Completion flag on finish, with interrupt tied to it.
// - Optional compare, less-than or greater-or-equal, raising interrupt.
// - Sample time and speed versus power are configurable.
// - Conversions continue in wait and shallow stop.
// - Control write aborts and restarts unless channel is all ones.
// - All-ones channel powers down, no extra conversion.
// - Done flag follows compare gating, cleared by write or low read.
module sac_ctrl #(
   parameter int RES_W = sac_pkg::RES_W,
   parameter int SAMPLE_SHORT = sac_pkg::SAMPLE_SHORT,
   parameter int SAMPLE_LONG = sac_pkg::SAMPLE_LONG
) (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic CTRL_WR,
   input wire logic [4:0] CHANNEL_SELECT,
   input wire logic CONTINUOUS,
   input wire logic IRQ_ENABLE,
   input wire logic HW_TRIG_ENABLE,
   input wire logic COMPARE_FUNCTION_ENABLE,
   input wire logic COMPARE_GREATER,
   input wire logic [RES_W-1:0] COMPARE_VALUE,
   input wire logic MODE_8BIT,
   input wire logic LONG_SAMPLE,
   input wire logic LOW_POWER,
   input wire logic [1:0] CLOCK_SOURCE,
   input wire logic [1:0] CLOCK_DIVIDE_FIELD,
   input wire logic [1:0] POWER_MODE,
   input wire logic RESULT_LOW_BYTE_READ,
   input wire logic HW_CONVERSION_TRIGGER,
   input wire logic ALTERNATE_CLOCK,
   input wire logic INTERNAL_ASYNC_CONV_CLOCK,
   input wire logic COMPARATOR_IN,
   output logic [RES_W-1:0] DAC_TRIAL,
   output logic [1:0] INPUT_KIND,
   output logic [3:0] EXT_INPUT,
   output logic [1:0] INT_SOURCE,
   output logic ANALOG_POWER_ON,
   output logic SAMPLING,
   output logic [RES_W-1:0] RESULT,
   output logic DONE_FLAG,
   output logic IRQ,
   output logic BUSY
);
   // Pins from outside the domain, two flops each
   logic [3:0] sy1_q, sy2_q;
   logic trig_prev_q;
   logic alt_prev_q, async_prev_q;
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         sy1_q <= 4'h0;
         sy2_q <= 4'h0;
         trig_prev_q <= 1'b0;
         alt_prev_q <= 1'b0;
         async_prev_q <= 1'b0;
      end else begin
         sy1_q <= {COMPARATOR_IN, INTERNAL_ASYNC_CONV_CLOCK, ALTERNATE_CLOCK,
            HW_CONVERSION_TRIGGER};
         sy2_q <= sy1_q;
         trig_prev_q <= sy2_q[0];
         alt_prev_q <= sy2_q[1];
         async_prev_q <= sy2_q[2];
      end
   end
   logic trig_evt, alt_tick, async_tick, cmp_s;
   // One event per overflow edge, counter irq enable not involved
   assign trig_evt = sy2_q[0] & ~trig_prev_q;
   assign alt_tick = sy2_q[1] & ~alt_prev_q;
   assign async_tick = sy2_q[2] & ~async_prev_q;
   assign cmp_s = sy2_q[3];

   // Conversion clock generation
   sac_tick_if tk ();
   assign tk.src = CLOCK_SOURCE;
   assign tk.div = CLOCK_DIVIDE_FIELD;
   assign tk.pwr = POWER_MODE;
   sac_clkdiv u_div (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .alt_tick(alt_tick),
      .async_tick(async_tick),
      .t(tk.gen)
   );

   typedef enum logic [1:0] {S_IDLE, S_ARMED, S_SAMPLE, S_CONVERT} sac_state_t;
   sac_state_t st_q, st_d;
   logic [sac_pkg::CNT_W-1:0] smp_q, smp_d;
   logic [RES_W-1:0] res_q, res_d;
   logic done_q, done_d, irq_q, irq_d;
   logic sar_start, sar_abort, sar_busy, sar_done;
   logic [RES_W-1:0] sar_trial;
   logic off, hw_ok, cmp_true;
   logic [sac_pkg::CNT_W-1:0] smp_len;
   logic [RES_W-1:0] fmt;

   // Trigger allowed in run, wait and shallow stop only
   assign hw_ok = POWER_MODE != sac_pkg::PWR_STOP2;
   assign off = CHANNEL_SELECT == sac_pkg::CH_OFF;
   // Speed/power option stretches sampling as the slower setting
   assign smp_len = (LONG_SAMPLE || LOW_POWER) ? sac_pkg::CNT_W'(SAMPLE_LONG)
      : sac_pkg::CNT_W'(SAMPLE_SHORT);
   // Eight-bit mode keeps the top bits, right-justified
   assign fmt = MODE_8BIT ? {2'b00, sar_trial[RES_W-1:2]} : sar_trial;
   assign cmp_true = COMPARE_GREATER ? (fmt >= COMPARE_VALUE)
      : (fmt < COMPARE_VALUE);

   sac_sar #(.RES_W(RES_W)) u_sar (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .tick(tk.tick),
      .start(sar_start),
      .abort(sar_abort),
      .cmp_in(cmp_s),
      .trial(sar_trial),
      .busy(sar_busy),
      .done(sar_done)
   );

   // Conversion sequencing
   always_comb begin
      st_d = st_q;
      smp_d = smp_q;
      res_d = res_q;
      done_d = done_q;
      sar_start = 1'b0;
      sar_abort = 1'b0;
      if (RESULT_LOW_BYTE_READ)
         done_d = 1'b0;
      case (st_q)
         S_IDLE: ;
         S_ARMED: begin
            if (HW_TRIG_ENABLE && trig_evt && hw_ok) begin
               st_d = S_SAMPLE;
               smp_d = '0;
            end
         end
         S_SAMPLE: begin
            if (tk.tick) begin
               if (smp_q + 1'b1 >= smp_len) begin
                  st_d = S_CONVERT;
                  sar_start = 1'b1;
               end else begin
                  smp_d = smp_q + 1'b1;
               end
            end
         end
         S_CONVERT: begin
            if (sar_done) begin
               res_d = fmt;
               if (!COMPARE_FUNCTION_ENABLE || cmp_true)
                  done_d = 1'b1;
               if (CONTINUOUS) begin
                  st_d = HW_TRIG_ENABLE ? S_ARMED : S_SAMPLE;
                  smp_d = '0;
               end else begin
                  st_d = HW_TRIG_ENABLE ? S_ARMED : S_IDLE;
               end
            end
         end
         default: st_d = S_IDLE;
      endcase
      // Control write wins over state, done flag and SAR start; a result finishing this cycle is still stored
      if (CTRL_WR) begin
         sar_abort = 1'b1;
         sar_start = 1'b0;
         done_d = 1'b0;
         smp_d = '0;
         if (off)
            st_d = S_IDLE;
         else if (HW_TRIG_ENABLE)
            st_d = S_ARMED;
         else
            st_d = S_SAMPLE;
      end
      irq_d = done_d && IRQ_ENABLE;
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         st_q <= S_IDLE;
         smp_q <= '0;
         res_q <= '0;
         done_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         st_q <= st_d;
         smp_q <= smp_d;
         res_q <= res_d;
         done_q <= done_d;
         irq_q <= irq_d;
      end
   end

   // Analog mux steering; reserved codes left unconnected
   logic [1:0] kind_d, kind_q, isrc_d, isrc_q;
   logic [3:0] ext_d, ext_q;
   logic pwr_d, pwr_q, smpo_q, busy_q;
   logic [RES_W-1:0] trial_q;
   always_comb begin
      kind_d = sac_pkg::SRC_NONE;
      isrc_d = sac_pkg::INT_VREFL;
      ext_d = CHANNEL_SELECT[3:0];
      if (CHANNEL_SELECT <= sac_pkg::CH_EXT_LAST)
         kind_d = sac_pkg::SRC_EXT;
      else if (CHANNEL_SELECT >= sac_pkg::CH_GND_FIRST
         && CHANNEL_SELECT <= sac_pkg::CH_GND_LAST)
         kind_d = sac_pkg::SRC_GND;
      else if (CHANNEL_SELECT == sac_pkg::CH_TEMP) begin
         kind_d = sac_pkg::SRC_INT;
         isrc_d = sac_pkg::INT_TEMP;
      end else if (CHANNEL_SELECT == sac_pkg::CH_BANDGAP) begin
         kind_d = sac_pkg::SRC_INT;
         isrc_d = sac_pkg::INT_BG;
      end else if (CHANNEL_SELECT == sac_pkg::CH_VREFH) begin
         kind_d = sac_pkg::SRC_INT;
         isrc_d = sac_pkg::INT_VREFH;
      end else if (CHANNEL_SELECT == sac_pkg::CH_VREFL) begin
         kind_d = sac_pkg::SRC_INT;
      end
      // Idle converter drops to low power automatically
      pwr_d = (st_d != S_IDLE) && !off;
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         kind_q <= sac_pkg::SRC_NONE;
         isrc_q <= sac_pkg::INT_VREFL;
         ext_q <= 4'h0;
         pwr_q <= 1'b0;
         smpo_q <= 1'b0;
         busy_q <= 1'b0;
         trial_q <= '0;
      end else begin
         kind_q <= kind_d;
         isrc_q <= isrc_d;
         ext_q <= ext_d;
         pwr_q <= pwr_d;
         smpo_q <= st_d == S_SAMPLE;
         busy_q <= st_d == S_SAMPLE || st_d == S_CONVERT;
         trial_q <= sar_trial;
      end
   end

   assign INPUT_KIND = kind_q;
   assign EXT_INPUT = ext_q;
   assign INT_SOURCE = isrc_q;
   assign ANALOG_POWER_ON = pwr_q;
   assign SAMPLING = smpo_q;
   assign BUSY = busy_q;
   assign DAC_TRIAL = trial_q;
   assign RESULT = res_q;
   assign DONE_FLAG = done_q;
   assign IRQ = irq_q;
endmodule

/* File: sac_props.sv */
module sac_props #(
   parameter int RES_W = 10
) (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic CTRL_WR,
   input wire logic [4:0] CHANNEL_SELECT,
   input wire logic IRQ_ENABLE,
   input wire logic HW_TRIG_ENABLE,
   input wire logic MODE_8BIT,
   input wire logic [1:0] POWER_MODE,
   input wire logic RESULT_LOW_BYTE_READ,
   input wire logic [RES_W-1:0] RESULT,
   input wire logic [1:0] INPUT_KIND,
   input wire logic [3:0] EXT_INPUT,
   input wire logic [1:0] INT_SOURCE,
   input wire logic ANALOG_POWER_ON,
   input wire logic DONE_FLAG,
   input wire logic IRQ,
   input wire logic BUSY
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   // Interrupt must track the flag while enabled
   irq_follows_a: assert property (
      DONE_FLAG && IRQ_ENABLE && $past(IRQ_ENABLE) |-> IRQ)
      else $error("irq missing with done set");
   // Disabled interrupt stays low whatever the flag does
   irq_gated_a: assert property (
      !$past(IRQ_ENABLE) |-> !IRQ)
      else $error("irq raised while disabled");
   // Off code must not leave one extra conversion behind
   off_quiet_a: assert property (
      CTRL_WR && CHANNEL_SELECT == sac_pkg::CH_OFF |=> (!BUSY && !ANALOG_POWER_ON)[*3])
      else $error("converter active after off code");
   wr_starts_a: assert property (
      CTRL_WR && CHANNEL_SELECT != sac_pkg::CH_OFF && !HW_TRIG_ENABLE
      && POWER_MODE == sac_pkg::PWR_RUN |=> BUSY)
      else $error("write did not start conversion");
   wr_clears_a: assert property (CTRL_WR |=> !DONE_FLAG)
      else $error("write left done set");
   // Read only clears when no completion is pending
   read_clears_a: assert property (
      RESULT_LOW_BYTE_READ && !CTRL_WR && !BUSY && !$past(BUSY, 3) |=> !DONE_FLAG)
      else $error("low byte read left done set");
   done_after_busy_a: assert property (
      $rose(DONE_FLAG) |-> $past(BUSY) || $past(BUSY, 2) || $past(BUSY, 3))
      else $error("done without conversion");
   byte_mode_a: assert property (
      $rose(DONE_FLAG) && MODE_8BIT |-> RESULT[9:8] == 2'h0)
      else $error("8-bit result not right justified");
   ext_map_a: assert property (
      CTRL_WR && CHANNEL_SELECT <= sac_pkg::CH_EXT_LAST |=> INPUT_KIND == sac_pkg::SRC_EXT
      && {1'b0, EXT_INPUT} == $past(CHANNEL_SELECT))
      else $error("external input mapping wrong");
   bg_map_a: assert property (
      CTRL_WR && CHANNEL_SELECT == sac_pkg::CH_BANDGAP |=> INPUT_KIND == sac_pkg::SRC_INT
      && INT_SOURCE == sac_pkg::INT_BG)
      else $error("bandgap mapping wrong");
   cov_done_c: cover property ($rose(DONE_FLAG));
   cov_off_c: cover property (CTRL_WR && CHANNEL_SELECT == sac_pkg::CH_OFF);
   cov_byte_c: cover property ($rose(DONE_FLAG) && MODE_8BIT);
endmodule

bind sac_ctrl sac_props #(.RES_W(RES_W)) u_sac_props (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
   .CTRL_WR(CTRL_WR), .CHANNEL_SELECT(CHANNEL_SELECT), .IRQ_ENABLE(IRQ_ENABLE),
   .HW_TRIG_ENABLE(HW_TRIG_ENABLE), .MODE_8BIT(MODE_8BIT), .POWER_MODE(POWER_MODE),
   .RESULT_LOW_BYTE_READ(RESULT_LOW_BYTE_READ), .RESULT(RESULT), .INPUT_KIND(INPUT_KIND),
   .EXT_INPUT(EXT_INPUT), .INT_SOURCE(INT_SOURCE), .ANALOG_POWER_ON(ANALOG_POWER_ON),
   .DONE_FLAG(DONE_FLAG), .IRQ(IRQ), .BUSY(BUSY));

/* File: sac_analog_model.sv */
module sac_analog_model (
   input wire logic clk,
   input wire logic bg_buf_en,
   input wire logic [9:0] trial,
   input wire logic [1:0] kind,
   input wire logic [3:0] ext,
   input wire logic [1:0] src,
   output logic cmp
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] vin;
   logic junk;
   logic flip = 1'b0;
   // Level of the routed source, taken as half an LSB above its code
   always_comb begin
      junk = kind == sac_pkg::SRC_NONE;
      case (kind)
         sac_pkg::SRC_EXT: vin = 10'(ext * 67 + 13);
         sac_pkg::SRC_GND: vin = 10'h000;
         sac_pkg::SRC_INT: vin = src == sac_pkg::INT_TEMP ? 10'h2C4 :
            src == sac_pkg::INT_BG ? 10'h175 : src == sac_pkg::INT_VREFH ? 10'h3FF : 10'h000;
         default: vin = 10'h000;
      endcase
      if (src == sac_pkg::INT_BG && kind == sac_pkg::SRC_INT && !bg_buf_en) junk = 1'b1;
   end
   // Unrouted or unbuffered input wanders every cycle
   always_ff @(posedge clk) flip <= ~flip;
   assign cmp = junk ? flip : ({vin, 1'b1} > {trial, 1'b0});
endmodule

/* File: sac_ctrl_tb.sv */
module sac_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0, rst_n = 1'b0, ctrl_wr = 1'b0, cont = 1'b0, irq_en = 1'b1;
   logic hw_en = 1'b0, cmp_en = 1'b0, cmp_ge = 1'b0, m8 = 1'b0, long_s = 1'b0;
   logic low_pw = 1'b0, rd_lo = 1'b0, hw_pin = 1'b0, alt_clk = 1'b0, async_clk = 1'b0;
   logic cmp_in, apwr, smp, done, irq, busy;
   logic [4:0] ch = 5'h00;
   logic [9:0] cmp_v = 10'h000;
   logic [9:0] trial, res;
   logic [1:0] csrc = 2'h0, cdiv = 2'h0, pmode = 2'h0;
   logic [1:0] kind, isrc;
   logic [3:0] ext;
   int fails = 0, tests_run = 0, seed = 32'h12B1, exp_q[$], c, e;
   int chs[6] = '{16, 21, 27, 26, 29, 30};
   sac_ctrl u_sac_ctrl (.CLK_SYS(clk_sys), .RST_N(rst_n), .CTRL_WR(ctrl_wr),
      .CHANNEL_SELECT(ch), .CONTINUOUS(cont), .IRQ_ENABLE(irq_en), .HW_TRIG_ENABLE(hw_en),
      .COMPARE_FUNCTION_ENABLE(cmp_en), .COMPARE_GREATER(cmp_ge), .COMPARE_VALUE(cmp_v),
      .MODE_8BIT(m8), .LONG_SAMPLE(long_s), .LOW_POWER(low_pw), .CLOCK_SOURCE(csrc),
      .CLOCK_DIVIDE_FIELD(cdiv), .POWER_MODE(pmode), .RESULT_LOW_BYTE_READ(rd_lo),
      .HW_CONVERSION_TRIGGER(hw_pin), .ALTERNATE_CLOCK(alt_clk),
      .INTERNAL_ASYNC_CONV_CLOCK(async_clk), .COMPARATOR_IN(cmp_in), .DAC_TRIAL(trial),
      .INPUT_KIND(kind), .EXT_INPUT(ext), .INT_SOURCE(isrc), .ANALOG_POWER_ON(apwr),
      .SAMPLING(smp), .RESULT(res), .DONE_FLAG(done), .IRQ(irq), .BUSY(busy));
   sac_analog_model u_sac_analog_model (.clk(clk_sys), .bg_buf_en(1'b1), .trial(trial),
      .kind(kind), .ext(ext), .src(isrc), .cmp(cmp_in));
   // Free-running clocks; the async one is unrelated in phase, the alternate one rises on system clock rising edges
   initial forever #10 clk_sys = ~clk_sys;
   initial forever #30 alt_clk = ~alt_clk;
   initial forever #17 async_clk = ~async_clk;
   // Expected level of each channel code
   function automatic int lvl(input int k);
      if (k < 16) return k * 67 + 13;
      return k == 26 ? 708 : k == 27 ? 373 : k == 29 ? 1023 : 0;
   endfunction
   task automatic cmp_val(input logic [9:0] got, input logic [9:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      cmp_val({9'h000, got}, {9'h000, exp});
   endtask
   task automatic wr(input int k);
      @(negedge clk_sys);
      ch = 5'(k);
      ctrl_wr = 1'b1;
      @(negedge clk_sys);
      ctrl_wr = 1'b0;
   endtask
   // Bounded wait for start then end of a conversion
   task automatic wait_idle;
      int n;
      n = 0;
      while (busy !== 1'b1 && n < 20) begin
         @(negedge clk_sys);
         n++;
      end
      while (busy !== 1'b0 && n < 8000) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 8000) cmp_bit(1'b1, 1'b0);
      repeat (4) @(negedge clk_sys);
   endtask
   task automatic wait_done;
      int n;
      n = 0;
      while (done !== 1'b1 && n < 8000) begin
         @(negedge clk_sys);
         n++;
      end
   endtask
   // Result, flag and interrupt against the model, then read clears
   task automatic check_conv(input int k, input logic exp_done);
      exp_q.push_back(m8 ? lvl(k) >> 2 : lvl(k));
      e = exp_q.pop_front();
      if (exp_done) cmp_val(res, 10'(e));
      cmp_bit(done, exp_done);
      cmp_bit(irq, exp_done & irq_en);
      rd_lo = 1'b1;
      @(negedge clk_sys);
      rd_lo = 1'b0;
      @(negedge clk_sys);
      cmp_bit(done, 1'b0);
   endtask
   task automatic hw_pulse;
      hw_pin = 1'b1;
      repeat (4) @(negedge clk_sys);
      hw_pin = 1'b0;
   endtask
   task automatic stop_test;
      $display("tests_run=%0d fails=%0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge clk_sys);
      fails++;
      $display("CHECK FAILED t=%0t watchdog expired", $time);
      stop_test();
   end
   initial begin
      repeat (10) @(negedge clk_sys);
      rst_n = 1'b1;
      // Codes 0-16, 21, 26, 27, 29 and 30, random clock, divider, format and sample
      for (int i = 0; i < 22; i++) begin
         c = i < 16 ? i : chs[i-16];
         {m8, long_s, low_pw, csrc, cdiv} = 7'($random(seed));
         if (c >= 26) long_s = 1'b1;
         wr(c);
         cmp_bit(smp, 1'b1);
         cmp_bit(apwr, 1'b1);
         if (c < 16) cmp_val({6'h00, ext}, 10'(c));
         wait_idle();
         e = c < 16 ? sac_pkg::SRC_EXT : c < 22 ? sac_pkg::SRC_GND : sac_pkg::SRC_INT;
         cmp_val({8'h00, kind}, 10'(e));
         if (c >= 26) cmp_val({8'h00, isrc}, c == 26 ? 0 : c == 27 ? 1 : c - 27);
         check_conv(c, 1'b1);
      end
      $display("test channel map done");
      m8 = 1'b0;
      csrc = sac_pkg::CLK_BUS;
      cdiv = 2'h0;
      // Reserved codes still complete, no error
      for (int j = 0; j < 2; j++) begin
         wr(j == 0 ? 22 : 28);
         wait_idle();
         cmp_val({8'h00, kind}, sac_pkg::SRC_NONE);
         cmp_bit(done, 1'b1);
      end
      $display("test reserved done");
      cmp_en = 1'b1;
      for (int k = 0; k < 4; k++) begin
         cmp_ge = k[0];
         irq_en = !k[1];
         cmp_v = 10'(lvl(5) + (k >> 1));
         wr(5);
         wait_idle();
         check_conv(5, cmp_ge ? k < 2 : k >= 2);
      end
      cmp_en = 1'b0;
      irq_en = 1'b1;
      $display("test compare done");
      long_s = 1'b1;
      wr(3);
      repeat (5) @(negedge clk_sys);
      wr(12);
      wait_idle();
      check_conv(12, 1'b1);
      $display("test abort done");
      cont = 1'b1;
      wr(9);
      wait_done();
      check_conv(9, 1'b1);
      wait_done();
      check_conv(9, 1'b1);
      wr(sac_pkg::CH_OFF);
      repeat (200) @(negedge clk_sys);
      cmp_bit(busy, 1'b0);
      cmp_bit(done, 1'b0);
      cmp_bit(apwr, 1'b0);
      cont = 1'b0;
      $display("test continuous done");
      // Counter overflow pin; no counter interrupt enable gates it
      hw_en = 1'b1;
      wr(7);
      repeat (10) @(negedge clk_sys);
      cmp_bit(busy, 1'b0);
      for (int k = 0; k < 4; k++) begin
         pmode = 2'(k);
         csrc = k == 1 ? sac_pkg::CLK_ALT : k == 0 ? sac_pkg::CLK_BUS : sac_pkg::CLK_ASYNC;
         hw_pulse();
         wait_idle();
         check_conv(7, k != 3);
         repeat (100) @(negedge clk_sys);
         cmp_bit(busy, 1'b0);
      end
      $display("test hardware trigger done");
      stop_test();
   end
endmodule
